// [hdl/hop_frame_sequencer.sv]
// Hop frame sequencer: front-end power ordering, frame delay and gain pick
`timescale 1ns/1ns
module hop_frame_sequencer #(
    parameter int DLY_W  = hop_seq_pkg::DLY_W,
    parameter int FRM_W  = hop_seq_pkg::FRM_W,
    parameter int GAIN_W = hop_seq_pkg::GAIN_W
) (
    input  wire logic                        clk_i,
    input  wire logic                        resetn_i,
    input  wire hop_seq_pkg::hop_mode_type   mode_i,
    input  wire hop_seq_pkg::timing_cfg_type timing_i,
    input  wire hop_seq_pkg::gain_cfg_type   gain_i,
    input  wire logic                        hop_i,
    input  wire logic                        rx_setup_i,
    input  wire logic                        tx_setup_i,
    input  wire logic                        obs_enable_i,
    output logic                             rx_analog_on_o,
    output logic                             tx_analog_on_o,
    output logic                             rx_interface_on_o,
    output logic                             obs_rx_on_o,
    output logic                             gain_load_o,
    output logic [GAIN_W-1:0]                gain_index_o
);

    // -------------------------------------------------------------------
    // Pin synchronisers and edge detect
    // -------------------------------------------------------------------
    logic [1:0] hop_sync_ff;
    logic [1:0] rxs_sync_ff;
    logic [1:0] txs_sync_ff;
    logic       hop_d_ff;
    logic       rxs_d_ff;
    logic       txs_d_ff;
    logic       hop_edge;
    logic       rxs_edge;
    logic       txs_edge;

    // First stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hop_sync_ff <= 2'h0;
            rxs_sync_ff <= 2'h0;
            txs_sync_ff <= 2'h0;
            hop_d_ff    <= 1'b0;
            rxs_d_ff    <= 1'b0;
            txs_d_ff    <= 1'b0;
        end else begin
            hop_sync_ff <= {hop_sync_ff[0], hop_i};
            rxs_sync_ff <= {rxs_sync_ff[0], rx_setup_i};
            txs_sync_ff <= {txs_sync_ff[0], tx_setup_i};
            hop_d_ff    <= hop_sync_ff[1];
            rxs_d_ff    <= rxs_sync_ff[1];
            txs_d_ff    <= txs_sync_ff[1];
        end
    end

    assign hop_edge = hop_sync_ff[1] & ~hop_d_ff;
    assign rxs_edge = rxs_sync_ff[1] & ~rxs_d_ff;
    assign txs_edge = txs_sync_ff[1] & ~txs_d_ff;

    // -------------------------------------------------------------------
    // Setup capture between hop edges
    // -------------------------------------------------------------------
    logic tx_setup_seen_ff;
    logic rx_setup_seen_ff;

    // A setup edge in the hop-edge cycle counts for the next frame
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_setup_seen_ff <= 1'b0;
            rx_setup_seen_ff <= 1'b0;
        end else if (hop_edge) begin
            tx_setup_seen_ff <= txs_edge;
            rx_setup_seen_ff <= rxs_edge;
        end else begin
            tx_setup_seen_ff <= tx_setup_seen_ff | txs_edge;
            rx_setup_seen_ff <= rx_setup_seen_ff | rxs_edge;
        end
    end

    // -------------------------------------------------------------------
    // Transmit frame delay and continuation
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_WAIT,
        TX_ACTIVE,
        TX_LAST
    } tx_state_type;

    tx_state_type     tx_state_ff;
    logic [FRM_W-1:0] frm_cnt_ff;
    logic [FRM_W-1:0] frame_delay;
    logic             tx_frame_start;
    logic             tx_frame;         // Current frame is transmit on air

    // Zero means one; only transmit-only accepts more than one
    always_comb begin
        if (timing_i.tx_analog_power_delay == hop_seq_pkg::FRM_ZERO) begin
            frame_delay = hop_seq_pkg::FRM_ONE;
        end else if (mode_i != hop_seq_pkg::MODE_TX_ONLY) begin
            frame_delay = hop_seq_pkg::FRM_ONE;
        end else begin
            frame_delay = timing_i.tx_analog_power_delay;
        end
    end

    assign tx_frame_start = hop_edge && (tx_state_ff == TX_WAIT) &&
                            (frm_cnt_ff == hop_seq_pkg::FRM_ONE);

    // Counts hop frames from the first setup edge
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tx_state_ff <= TX_IDLE;
            frm_cnt_ff  <= hop_seq_pkg::FRM_ZERO;
        end else begin
            case (tx_state_ff)
                TX_IDLE: begin
                    if (txs_edge) begin
                        tx_state_ff <= TX_WAIT;
                        frm_cnt_ff  <= frame_delay;
                    end
                end
                TX_WAIT: begin
                    if (hop_edge) begin
                        if (frm_cnt_ff == hop_seq_pkg::FRM_ONE) begin
                            tx_state_ff <= TX_ACTIVE;
                        end else begin
                            frm_cnt_ff <= frm_cnt_ff - hop_seq_pkg::FRM_ONE;
                        end
                    end
                end
                TX_ACTIVE: begin
                    // Hop without preceding setup: this frame is the last
                    if (hop_edge && !tx_setup_seen_ff) begin
                        tx_state_ff <= TX_LAST;
                    end
                end
                TX_LAST: begin
                    if (hop_edge) begin
                        tx_state_ff <= TX_IDLE;
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    // The last frame still transmits; power drops at the hop that ends it
    assign tx_frame = (tx_state_ff == TX_ACTIVE) || (tx_state_ff == TX_LAST);

    // -------------------------------------------------------------------
    // Receive frame tracking
    // -------------------------------------------------------------------
    logic rx_frame_ff;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_frame_ff <= 1'b0;
        end else if (hop_edge) begin
            rx_frame_ff <= rx_setup_seen_ff | rxs_edge;
        end
    end

    // -------------------------------------------------------------------
    // Power-up delay counters
    // -------------------------------------------------------------------
    logic [DLY_W-1:0] rx_dly;
    logic [DLY_W-1:0] tx_dly;
    logic [DLY_W-1:0] relock;
    logic [DLY_W-1:0] rx_cnt_ff;
    logic [DLY_W-1:0] tx_cnt_ff;
    logic             rx_pend_ff;
    logic             tx_pend_ff;
    localparam logic [DLY_W-1:0] GUARD = DLY_W'(hop_seq_pkg::GUARD_CYC);

    function automatic logic [DLY_W-1:0] max2(input logic [DLY_W-1:0] a,
                                             input logic [DLY_W-1:0] b);
        return (a > b) ? a : b;
    endfunction

    // Receive clamp keeps transmit power-down ahead of receive power-up
    always_comb begin
        relock = timing_i.relock_needed ?
                 hop_seq_pkg::relock_cycles(timing_i.clk_band, timing_i.relock_fast) :
                 '0;
        rx_dly = max2(max2(timing_i.rx_analog_on_delay, GUARD), relock);
        tx_dly = max2(timing_i.tx_analog_on_delay, relock);
    end

    // Counters start on the hop edge that opens the frame
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_cnt_ff  <= '0;
            tx_cnt_ff  <= '0;
            rx_pend_ff <= 1'b0;
            tx_pend_ff <= 1'b0;
        end else begin
            if (hop_edge) begin
                rx_pend_ff <= rx_setup_seen_ff | rxs_edge;
                rx_cnt_ff  <= rx_dly;
            end else if (rx_pend_ff && rx_cnt_ff != '0) begin
                rx_cnt_ff <= rx_cnt_ff - 1'b1;
            end else begin
                rx_pend_ff <= 1'b0;
            end
            if (tx_frame_start || (hop_edge && tx_state_ff == TX_ACTIVE)) begin
                tx_pend_ff <= 1'b1;
                tx_cnt_ff  <= tx_dly;
            end else if (hop_edge) begin
                tx_pend_ff <= 1'b0;
            end else if (tx_pend_ff && tx_cnt_ff != '0) begin
                tx_cnt_ff <= tx_cnt_ff - 1'b1;
            end else begin
                tx_pend_ff <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Analog front-end power
    // -------------------------------------------------------------------
    // Every hop edge powers receive down, and transmit too unless the state is TX_ACTIVE; each rises after its delay
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_analog_on_o <= 1'b0;
            tx_analog_on_o <= 1'b0;
        end else if (hop_edge) begin
            rx_analog_on_o <= 1'b0;
            tx_analog_on_o <= tx_analog_on_o & (tx_state_ff == TX_ACTIVE);
        end else begin
            if (rx_pend_ff && rx_cnt_ff == '0 && !tx_analog_on_o && !tx_frame) begin
                rx_analog_on_o <= 1'b1;
            end
            if (tx_pend_ff && tx_cnt_ff == '0 && !rx_analog_on_o && tx_frame) begin
                tx_analog_on_o <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------------
    // Receive interface hold after frame
    // -------------------------------------------------------------------
    logic [DLY_W-1:0] hold_cnt_ff;

    // Hold may span several hop frames, so it is a free counter
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rx_interface_on_o <= 1'b0;
            hold_cnt_ff       <= '0;
        end else if (hop_edge && (rx_setup_seen_ff | rxs_edge)) begin
            rx_interface_on_o <= 1'b1;
            hold_cnt_ff       <= '0;
        end else if (hop_edge && rx_frame_ff) begin
            hold_cnt_ff <= timing_i.rx_interface_hold_time;
            rx_interface_on_o <= (timing_i.rx_interface_hold_time != '0);
        end else if (hold_cnt_ff != '0) begin
            hold_cnt_ff <= hold_cnt_ff - 1'b1;
            if (hold_cnt_ff == DLY_W'(1)) begin
                rx_interface_on_o <= 1'b0;
            end
        end
    end

    // -------------------------------------------------------------------
    // Observation receiver turn-on
    // -------------------------------------------------------------------
    localparam int OBS_W = $clog2(hop_seq_pkg::OBS_ON_CYC + 1);
    localparam logic [OBS_W-1:0] OBS_CYC = OBS_W'(hop_seq_pkg::OBS_ON_CYC);
    logic [OBS_W-1:0] obs_cnt_ff;

    // Dropped immediately; turn-off time is not characterized
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            obs_cnt_ff  <= '0;
            obs_rx_on_o <= 1'b0;
        end else if (!obs_enable_i) begin
            obs_cnt_ff  <= '0;
            obs_rx_on_o <= 1'b0;
        end else if (obs_cnt_ff != OBS_CYC) begin
            obs_cnt_ff <= obs_cnt_ff + 1'b1;
            obs_rx_on_o <= (obs_cnt_ff == OBS_CYC - 1'b1);
        end
    end

    // -------------------------------------------------------------------
    // Per-frame receive gain
    // -------------------------------------------------------------------
    // Load at a receive frame start unless the gain loop carries on
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            gain_load_o  <= 1'b0;
            gain_index_o <= '0;
        end else begin
            gain_load_o <= 1'b0;
            if (hop_edge && (rx_setup_seen_ff | rxs_edge)) begin
                if (!gain_i.agc_enable) begin
                    gain_load_o  <= 1'b1;
                    gain_index_o <= gain_i.table_gain;
                end else if (gain_i.gain_restart_per_frame) begin
                    gain_load_o  <= 1'b1;
                    gain_index_o <= gain_i.table_gain;
                end
            end
        end
    end

endmodule // hop_frame_sequencer

// [hdl/hop_seq_pkg.sv]
// Constants and carrier types for the hop frame sequencer
//
// Behaviour
// - Never power receive and transmit together
// - Receive delay clamped to guard interval minimum
// - Transmit delay has no minimum
// - Power-up waits max of relock and delay
// - Relock time set by clock and mode
// - Receive interface held after last frame
// - Transmit power delayed programmed hop frames in transmit-only mode; one frame in the other modes
// - Frame delay at least one; zero means one
// - Missing setup pulse ends transmit next hop
// - Observation receiver on eight microseconds after enable
// - Restart flag selects carry or restart gain
// - Restart gain taken from hop-table entry
// - Manual gain taken from hop-table entry
// - Guard interval fixed at 0.15 microseconds
package hop_seq_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int CLK_HZ              = 10_000_000;
    localparam int GUARD_NS            = 150;   // front_end_guard_interval
    localparam int GUARD_CYC_RAW       = (GUARD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int GUARD_CYC           = (GUARD_CYC_RAW < 1) ? 1 : GUARD_CYC_RAW;
    localparam int OBS_ON_US           = 8;     // obs_rx_turn_on_time
    localparam int OBS_ON_CYC          = OBS_ON_US * (CLK_HZ / 1_000_000);
    localparam int DLY_W               = 16;
    localparam int FRM_W               = 8;
    localparam int GAIN_W              = 8;

    localparam logic [FRM_W-1:0] FRM_ONE  = 8'h01;
    localparam logic [FRM_W-1:0] FRM_ZERO = 8'h00;

    // Relock lookup: device clock band, fast and normal figures in us
    localparam int RELOCK_BANDS = 6;
    localparam int RELOCK_FAST_US   [RELOCK_BANDS] = '{50, 25, 20, 17, 15, 14};
    localparam int RELOCK_NORMAL_US [RELOCK_BANDS] = '{170, 160, 155, 150, 145, 140};

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_RX_ONLY,
        MODE_TX_ONLY,
        MODE_TRX
    } hop_mode_type;

    typedef struct packed {
        logic [DLY_W-1:0] rx_analog_on_delay;
        logic [DLY_W-1:0] tx_analog_on_delay;
        logic [DLY_W-1:0] rx_interface_hold_time;
        logic [FRM_W-1:0] tx_analog_power_delay;
        logic [2:0]       clk_band;     // 0 = 50 MHz ... 5 = 300 MHz
        logic             relock_fast;
        logic             relock_needed;
    } timing_cfg_type;

    typedef struct packed {
        logic              agc_enable;
        logic              gain_restart_per_frame;
        logic [GAIN_W-1:0] gain_restart_index;
        logic [GAIN_W-1:0] table_gain;
    } gain_cfg_type;

    // Relock time in clock cycles from the band and mode
    function automatic logic [DLY_W-1:0] relock_cycles(input logic [2:0] band,
                                                       input logic       fast);
        int idx;
        int us;
        idx = (int'(band) < RELOCK_BANDS) ? int'(band) : RELOCK_BANDS - 1;
        us  = fast ? RELOCK_FAST_US[idx] : RELOCK_NORMAL_US[idx];
        return DLY_W'(us * (CLK_HZ / 1_000_000));
    endfunction

endpackage

// [verification/hop_seq_chk.sv]
// Port-level assertions for the hop frame sequencer
`timescale 1ns/1ns
module hop_seq_chk #(
    parameter int DLY_W  = 16,
    parameter int FRM_W  = 8,
    parameter int GAIN_W = 8
) (
    input wire logic                        clk_i,
    input wire logic                        resetn_i,
    input wire hop_seq_pkg::hop_mode_type   mode_i,
    input wire hop_seq_pkg::timing_cfg_type timing_i,
    input wire hop_seq_pkg::gain_cfg_type   gain_i,
    input wire logic                        hop_i,
    input wire logic                        rx_setup_i,
    input wire logic                        tx_setup_i,
    input wire logic                        obs_enable_i,
    input wire logic                        rx_analog_on_o,
    input wire logic                        tx_analog_on_o,
    input wire logic                        rx_interface_on_o,
    input wire logic                        obs_rx_on_o,
    input wire logic                        gain_load_o,
    input wire logic [GAIN_W-1:0]           gain_index_o
);
    // -----------------------------------------------------------------
    // Helper counters
    // -----------------------------------------------------------------
    logic [15:0] since_ff;
    logic [15:0] obs_ff;
    logic        hop_ff;
    logic [15:0] relock;

    // Relock in cycles, 10 cycles per microsecond
    always_comb begin
        relock = 16'(10 * (timing_i.relock_fast ? hop_seq_pkg::RELOCK_FAST_US[timing_i.clk_band]
                         : hop_seq_pkg::RELOCK_NORMAL_US[timing_i.clk_band]));
    end

    // Cycles since the hop pin rose; saturates so long idles never wrap
    always_ff @(posedge clk_i) begin
        hop_ff <= hop_i;
        if (!resetn_i || (hop_i && !hop_ff)) since_ff <= 16'h0000;
        else if (since_ff != 16'hFFFF) since_ff <= since_ff + 16'h0001;
    end

    // Cycles the observation enable has been high without a break
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !obs_enable_i) obs_ff <= 16'h0000;
        else if (obs_ff != 16'hFFFF) obs_ff <= obs_ff + 16'h0001;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_fe_exclusive: assert property (!(rx_analog_on_o && tx_analog_on_o))
        else $error("receive and transmit front ends on together");
    a_rx_guard_gap: assert property ($rose(rx_analog_on_o) |->
        !$past(tx_analog_on_o) && !$past(tx_analog_on_o, 2))
        else $error("receive power-up without guard gap");
    a_tx_after_rx: assert property ($rose(tx_analog_on_o) |-> !$past(rx_analog_on_o))
        else $error("transmit power-up before receive power-down");
    a_rx_wait_time: assert property ($rose(rx_analog_on_o) |-> since_ff >= 16'h0002
        && since_ff >= timing_i.rx_analog_on_delay
        && (!timing_i.relock_needed || since_ff >= relock))
        else $error("receive power-up too early");
    a_tx_wait_time: assert property ($rose(tx_analog_on_o) |->
        since_ff >= timing_i.tx_analog_on_delay && (!timing_i.relock_needed || since_ff >= relock))
        else $error("transmit power-up too early");
    a_obs_turn_on: assert property ($rose(obs_rx_on_o) |-> obs_ff >= 16'h0050)
        else $error("observation receiver on too soon");
    a_obs_turn_off: assert property (!obs_enable_i [*4] |-> !obs_rx_on_o)
        else $error("observation receiver on without enable");
    a_gain_pulse: assert property (gain_load_o |=> !gain_load_o)
        else $error("gain load longer than one cycle");
    a_gain_source: assert property (gain_load_o |-> gain_index_o == gain_i.table_gain)
        else $error("gain index not from hop table");
    a_carry_no_load: assert property (gain_load_o |->
        !gain_i.agc_enable || gain_i.gain_restart_per_frame)
        else $error("gain loaded while loop carries state");
endmodule // hop_seq_chk

bind hop_frame_sequencer hop_seq_chk #(.DLY_W(DLY_W), .FRM_W(FRM_W), .GAIN_W(GAIN_W)) chk (.*);

// [verification/hop_ctrl_model.sv]
// Controller model driving hop, setup and observation pins
`timescale 1ns/1ns
module hop_ctrl_model (
    input  wire logic clk_i,
    output logic      hop_o,
    output logic      rx_setup_o,
    output logic      tx_setup_o,
    output logic      obs_enable_o
);
    // Pins idle low from time zero
    initial begin
        {hop_o, rx_setup_o, tx_setup_o, obs_enable_o} = 4'h0;
    end

    // Setup pulses rise 16 cycles before the hop, over the 1 us minimum
    task automatic hop(input logic tx, input logic rx);
        @(negedge clk_i);
        tx_setup_o = tx;
        rx_setup_o = rx;
        repeat (4) @(negedge clk_i);
        // Setup falls early; data padding stays on the controller's own link
        {tx_setup_o, rx_setup_o} = 2'h0;
        repeat (12) @(negedge clk_i);
        hop_o = 1'b1;
        repeat (4) @(negedge clk_i);
        hop_o = 1'b0;
    endtask

    // Window lies wholly inside the current transmit frame
    task automatic obs(input int on_cyc);
        repeat (20) @(negedge clk_i);
        obs_enable_o = 1'b1;
        repeat (on_cyc) @(negedge clk_i);
        obs_enable_o = 1'b0;
    endtask
endmodule // hop_ctrl_model

// [verification/testbench.sv]
// Self-checking bench for the hop frame sequencer
`timescale 1ns/1ns
module testbench;
    logic                        clk_i;
    logic                        resetn_i;
    logic                        hop_i;
    logic                        rx_setup_i;
    logic                        tx_setup_i;
    logic                        obs_enable_i;
    hop_seq_pkg::hop_mode_type   mode_i;
    hop_seq_pkg::timing_cfg_type timing_i;
    hop_seq_pkg::gain_cfg_type   gain_i;
    logic                        rx_analog_on_o;
    logic                        tx_analog_on_o;
    logic                        rx_interface_on_o;
    logic                        obs_rx_on_o;
    logic                        gain_load_o;
    logic [7:0]                  gain_index_o;
    logic [7:0]                  load_val;
    logic                        load_seen;
    logic                        hop_q = 1'b0;
    logic                        rx_q = 1'b0;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int hop_cyc = 0;
    int rx_cyc = 0;

    hop_frame_sequencer uut (.*);
    hop_ctrl_model ctl (.clk_i(clk_i), .hop_o(hop_i), .rx_setup_o(rx_setup_i),
                        .tx_setup_o(tx_setup_i), .obs_enable_o(obs_enable_i));

    // 10 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Edge times, gain loads and the hang limit
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        hop_q <= hop_i;
        rx_q <= rx_analog_on_o;
        if (hop_i && !hop_q) hop_cyc <= cyc;
        if (rx_analog_on_o && !rx_q) rx_cyc <= cyc;
        if (gain_load_o) load_seen <= 1'b1;
        if (gain_load_o) load_val <= gain_index_o;
        if (cyc == 40000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic check(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // Config is changed just before each reset
    task automatic cfg(input hop_seq_pkg::hop_mode_type m, input logic [15:0] rxd, hold,
                       input logic [7:0] frm, input logic [2:0] band, input logic fast, rl);
        mode_i = m;
        timing_i = '{rxd, 16'h0005, hold, frm, band, fast, rl};
    endtask

    task automatic do_reset(input int n);
        resetn_i = 1'b0;
        repeat (n) @(negedge clk_i);
        resetn_i = 1'b1;
    endtask

    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_tx_delay(input hop_seq_pkg::hop_mode_type m, input logic [7:0] frm,
                              input int expn);
        cfg(m, 16'h0000, 16'h0000, frm, 3'h0, 1'b0, 1'b0);
        do_reset(3);
        for (int k = 1; k <= 4; k++) begin
            ctl.hop(1'b1, 1'b0);
            repeat (30) @(negedge clk_i);
            check(tx_analog_on_o, k >= expn, "tx frame delay");
        end
        ctl.hop(1'b0, 1'b0);
        repeat (30) @(negedge clk_i);
        check(tx_analog_on_o, 1'b1, "tx last frame kept");
        ctl.hop(1'b0, 1'b0);
        repeat (30) @(negedge clk_i);
        check(tx_analog_on_o, 1'b0, "tx not powered down");
        $display("test tx delay %0d done", frm);
    endtask

    task automatic t_rx(input logic [15:0] rxd, input logic [2:0] band, input logic fast, rl,
                        input int expd);
        int d;
        cfg(hop_seq_pkg::MODE_RX_ONLY, rxd, 16'h0000, 8'h01, band, fast, rl);
        do_reset(3);
        ctl.hop(1'b0, 1'b1);
        for (int i = 0; i < 2000 && rx_analog_on_o !== 1'b1; i++) @(negedge clk_i);
        @(negedge clk_i);   // Edge log records the rise one clock later
        d = rx_cyc - hop_cyc;
        check(d >= expd + 4 && d <= expd + 7, 1'b1, "rx power-up time");
        ctl.hop(1'b0, 1'b0);
        $display("test rx delay %0d done", expd);
    endtask

    // Tx frame hands over to an rx frame on one hop edge
    task automatic t_trx();
        cfg(hop_seq_pkg::MODE_TRX, 16'h0000, 16'h0000, 8'h03, 3'h0, 1'b0, 1'b0);
        do_reset(3);
        ctl.hop(1'b1, 1'b0);
        ctl.hop(1'b0, 1'b0);
        ctl.hop(1'b0, 1'b1);
        repeat (20) @(negedge clk_i);
        check(tx_analog_on_o, 1'b0, "tx still on in rx frame");
        check(rx_analog_on_o, 1'b1, "rx frame missing");
        check(rx_cyc - hop_cyc >= 6, 1'b1, "rx before guard");
        $display("test trx handover done");
    endtask

    // Hold of 300 cycles outlives the frame
    task automatic t_hold();
        cfg(hop_seq_pkg::MODE_RX_ONLY, 16'h0000, 16'h012C, 8'h01, 3'h0, 1'b0, 1'b0);
        do_reset(3);
        ctl.hop(1'b0, 1'b1);
        ctl.hop(1'b0, 1'b0);
        repeat (250) @(negedge clk_i);
        check(rx_analog_on_o, 1'b0, "rx front end kept on");
        check(rx_interface_on_o, 1'b1, "interface dropped early");
        repeat (80) @(negedge clk_i);
        check(rx_interface_on_o, 1'b0, "interface held too long");
        $display("test rx hold done");
    endtask

    task automatic t_gain(input logic agc, input logic rst, input logic exp);
        gain_i = '{agc, rst, 8'h3C, 8'hA5};
        cfg(hop_seq_pkg::MODE_RX_ONLY, 16'h0000, 16'h0000, 8'h01, 3'h0, 1'b0, 1'b0);
        do_reset(3);
        load_seen = 1'b0;
        ctl.hop(1'b0, 1'b1);
        repeat (10) @(negedge clk_i);
        check(load_seen, exp, "gain load");
        if (exp) check(load_val == 8'hA5, 1'b1, "gain index");
        ctl.hop(1'b0, 1'b0);
        $display("test gain %0d%0d done", agc, rst);
    endtask

    task automatic t_obs();
        cfg(hop_seq_pkg::MODE_TX_ONLY, 16'h0000, 16'h0000, 8'h01, 3'h0, 1'b0, 1'b0);
        do_reset(3);
        ctl.hop(1'b1, 1'b0);
        fork
            ctl.obs(120);
            begin
                repeat (95) @(negedge clk_i);
                check(obs_rx_on_o, 1'b0, "observation on too soon");
                repeat (13) @(negedge clk_i);
                check(obs_rx_on_o, 1'b1, "observation not on");
            end
        join
        repeat (6) @(negedge clk_i);
        check(obs_rx_on_o, 1'b0, "observation not off");
        $display("test observation done");
    endtask

    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        gain_i = '{1'b0, 1'b0, 8'h3C, 8'hA5};
        cfg(hop_seq_pkg::MODE_RX_ONLY, 16'h0000, 16'h0000, 8'h01, 3'h0, 1'b0, 1'b0);
        do_reset(20);
        t_tx_delay(hop_seq_pkg::MODE_TX_ONLY, 8'h00, 1);
        t_tx_delay(hop_seq_pkg::MODE_TX_ONLY, 8'h03, 3);
        t_tx_delay(hop_seq_pkg::MODE_TRX, 8'h03, 1);
        t_rx(16'h0000, 3'h0, 1'b0, 1'b0, 2);
        t_rx(16'h0014, 3'h5, 1'b1, 1'b1, 140);
        t_rx(16'h0014, 3'h0, 1'b0, 1'b1, 1700);
        t_rx(16'h012C, 3'h5, 1'b1, 1'b1, 300);
        t_trx();
        t_hold();
        t_gain(1'b0, 1'b0, 1'b1);
        t_gain(1'b1, 1'b1, 1'b1);
        t_gain(1'b1, 1'b0, 1'b0);
        t_obs();
        summarize();
    end
endmodule // testbench
